/* File: rtl/rsr_pkg.sv */
// package: constants and types for the reset cause register block
package rsr_pkg;

  // register location on the special function register port
  localparam logic [7:0] RSR_CAUSE_ADDR = 8'hef;
  localparam logic [3:0] RSR_CAUSE_PAGE = 4'h0;

  // bit positions inside the reset cause register
  localparam int RSR_BIT_CLOCK_ALARM = 7;
  localparam int RSR_BIT_MEMORY_ERROR = 6;
  localparam int RSR_BIT_COMPARATOR = 5;
  localparam int RSR_BIT_SOFTWARE = 4;
  localparam int RSR_BIT_WATCHDOG = 3;
  localparam int RSR_BIT_MISSING_CLOCK = 2;
  localparam int RSR_BIT_POWER_ON = 1;
  localparam int RSR_BIT_EXT_PIN = 0;

  // values after a power-on reset
  localparam logic [7:0] RSR_FLAGS_POR = 8'h02;
  localparam logic [3:0] RSR_ENABLES_POR = 4'h0;

  // length of the system reset pulse that this block drives
  localparam logic [7:0] RSR_HOLD_CYCLES = 8'h10;

  // missing clock timeout, longest time rounds down to whole cycles
  localparam int RSR_MCD_TIMEOUT_US = 100;
  localparam int RSR_CLK_PERIOD_NS = 4;
  localparam int RSR_MCD_TIMEOUT_CYCLES = (RSR_MCD_TIMEOUT_US * 1000) / RSR_CLK_PERIOD_NS;

  // synchroniser lanes: 0 alarm, 1 mem err, 2 cmp_n, 3 watchdog, 4 supply low,
  // 5 monitor on, 6 pin_n, 7 low power, 8 clock beat
  localparam int RSR_SYNC_LANES = 9;
  localparam logic [8:0] RSR_SYNC_INIT = 9'h044;

  // cause flags, one per reset source, laid out as the register bits
  typedef struct packed {
    logic clock_alarm;
    logic memory_error;
    logic comparator;
    logic software;
    logic watchdog;
    logic missing_clock;
    logic power_on;
    logic ext_pin;
  } rsr_flags_t;

  // reset source enables, kept across all but power-on
  typedef struct packed {
    logic clock_alarm;
    logic comparator;
    logic missing_clock;
    logic supply_monitor;
  } rsr_en_t;

  typedef enum logic [0:0] {
    RSR_IDLE = 1'b0,
    RSR_HOLD = 1'b1
  } rsr_state_t;

endpackage

/* File: rtl/rsr_clock_watch.sv */
// missing clock detector: times out when the core clock beat stops toggling
`timescale 1ns/100ps
`default_nettype none
module rsr_clock_watch #(
  parameter int TIMEOUT_CYCLES = rsr_pkg::RSR_MCD_TIMEOUT_CYCLES,
  parameter int CNT_W = $clog2(TIMEOUT_CYCLES + 1)
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // control
  input wire logic enable_in,
  input wire logic beat_in,
  // result
  output logic timeout_out
);

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_CYCLES - 1);

  logic beat_q;
  logic beat_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic timeout_q;
  logic timeout_d;
  logic beat_edge;

  assign beat_edge = beat_in ^ beat_q;

  // count cycles since the last level change of the beat
  always_comb
  begin
    beat_d = beat_in;
    cnt_d = cnt_q;
    timeout_d = 1'b0;
    if (!enable_in || beat_edge)
    begin
      cnt_d = '0;
    end
    else if (cnt_q == LIMIT)
    begin
      timeout_d = 1'b1;
      cnt_d = '0;
    end
    else
    begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      beat_q <= 1'b0;
      cnt_q <= '0;
      timeout_q <= 1'b0;
    end
    else
    begin
      beat_q <= beat_d;
      cnt_q <= cnt_d;
      timeout_q <= timeout_d;
    end
  end

  assign timeout_out = timeout_q;

  a_beat_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (beat_edge || !enable_in) |=> !timeout_out)
  else $error("clock watch timed out right after a beat or while disabled");

endmodule
`default_nettype wire

/* File: rtl/rsr_reset_cause.sv */
// reset cause register: records the last reset source and gates reset sources
//
// Contract
// - bit 7 enables clock alarm reset; reads 1 if clock caused reset.
// - bit 6 read-only, set when a memory access error caused reset.
// - bit 5 enables comparator reset; reads 1 if comparator caused reset.
// - writing 1 to bit 4 starts a system reset at once.
// - after a software forced reset bit 4 reads 1.
// - bit 3 read-only, set when watchdog overflow caused reset.
// - bit 2 enables missing clock detector; reads 1 if it caused reset.
// - bit 1 reads 1 after power-on or supply reset; write enables monitor.
// - bit 0 read-only, set when the external reset pin caused reset.
// - read-modify-write of enable bits causes no unintended side effects; the code forces a reset if bit 4 reads 1 and is written back.
// - eight-bit register at address 0xEF on page 0; reset value varies.
// - missing clock detector fires after clock stalls beyond 100 us.
// - missing clock and watchdog sources are off during low power.
// - supply monitor resets only when both its enables are set.
`timescale 1ns/100ps
`default_nettype none
module rsr_reset_cause #(
  parameter int MCD_TIMEOUT_CYCLES = rsr_pkg::RSR_MCD_TIMEOUT_CYCLES
) (
  // clock and power-on reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // special function register port
  input wire logic [3:0] reg_page_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // reset sources, all asynchronous to clk_sys_in
  input wire logic clock_alarm_event_in,
  input wire logic memory_error_in,
  input wire logic comparator_trip_n_in,
  input wire logic watchdog_overflow_in,
  input wire logic supply_low_in,
  input wire logic supply_monitor_enable_in,
  input wire logic ext_reset_n_in,
  input wire logic low_power_in,
  input wire logic core_clock_beat_in,
  // results
  output logic system_reset_out,
  output rsr_pkg::rsr_en_t reset_enables_out
);

  logic [rsr_pkg::RSR_SYNC_LANES-1:0] meta_q;
  logic [rsr_pkg::RSR_SYNC_LANES-1:0] sync_q;
  logic [rsr_pkg::RSR_SYNC_LANES-1:0] raw_in;
  logic alarm_s, mem_s, cmp_n_s, wd_s, sup_low_s, mon_on_s, pin_n_s, lp_s, beat_s;
  logic mcd_timeout;
  logic reg_hit, wr_hit, rd_hit;
  rsr_pkg::rsr_flags_t flags_q, flags_d, cause;
  rsr_pkg::rsr_en_t en_q, en_d;
  rsr_pkg::rsr_state_t st_q, st_d;
  logic [7:0] hold_q, hold_d;
  logic [7:0] rdata_q, rdata_d;

  // raw source levels gathered into lanes in the order of the init pattern
  assign raw_in = {core_clock_beat_in, low_power_in, ext_reset_n_in,
                   supply_monitor_enable_in, supply_low_in, watchdog_overflow_in,
                   comparator_trip_n_in, memory_error_in, clock_alarm_event_in};

  // two-stage synchronisers; pins idle high for the active-low ones
  for (genvar i = 0; i < rsr_pkg::RSR_SYNC_LANES; i++)
  begin : g_sync
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        meta_q[i] <= rsr_pkg::RSR_SYNC_INIT[i];
        sync_q[i] <= rsr_pkg::RSR_SYNC_INIT[i];
      end
      else
      begin
        meta_q[i] <= raw_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign {beat_s, lp_s, pin_n_s, mon_on_s, sup_low_s, wd_s, cmp_n_s, mem_s, alarm_s} = sync_q;

  // detector is held cleared in low power and while the reset pulse stands
  rsr_clock_watch #(
    .TIMEOUT_CYCLES(MCD_TIMEOUT_CYCLES)
  ) u_clock_watch (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .enable_in(en_q.missing_clock && !lp_s && st_q == rsr_pkg::RSR_IDLE),
    .beat_in(beat_s),
    .timeout_out(mcd_timeout)
  );

  // register decode; accesses are ignored while the system is held in reset
  assign reg_hit = (reg_addr_in == rsr_pkg::RSR_CAUSE_ADDR)
                   && (reg_page_in == rsr_pkg::RSR_CAUSE_PAGE);
  assign wr_hit = reg_hit && reg_wr_in && st_q == rsr_pkg::RSR_IDLE;
  assign rd_hit = reg_hit && reg_rd_in && st_q == rsr_pkg::RSR_IDLE;

  // one source wins per reset; the pin is strongest since it holds the whole chip
  always_comb
  begin
    cause = '0;
    if (!pin_n_s)
      cause.ext_pin = 1'b1;
    else if (sup_low_s && mon_on_s && en_q.supply_monitor)
      cause.power_on = 1'b1;
    // the timeout is one cycle old, so mask it again against low power entry
    else if (mcd_timeout && !lp_s)
      cause.missing_clock = 1'b1;
    else if (wd_s && !lp_s)
      cause.watchdog = 1'b1;
    else if (mem_s)
      cause.memory_error = 1'b1;
    else if (!cmp_n_s && en_q.comparator)
      cause.comparator = 1'b1;
    else if (alarm_s && en_q.clock_alarm)
      cause.clock_alarm = 1'b1;
    else if (wr_hit && reg_wdata_in[rsr_pkg::RSR_BIT_SOFTWARE])
      cause.software = 1'b1;
  end

  // register access and reset sequencing
  always_comb
  begin
    flags_d = flags_q;
    en_d = en_q;
    st_d = st_q;
    hold_d = hold_q;
    rdata_d = 8'h00;
    if (rd_hit)
      rdata_d = flags_q;
    // read-only bits drop writes, so rewriting a read value changes only enables, except that a read bit 4 written back forces a reset
    if (wr_hit)
    begin
      en_d.clock_alarm = reg_wdata_in[rsr_pkg::RSR_BIT_CLOCK_ALARM];
      en_d.comparator = reg_wdata_in[rsr_pkg::RSR_BIT_COMPARATOR];
      en_d.missing_clock = reg_wdata_in[rsr_pkg::RSR_BIT_MISSING_CLOCK];
      en_d.supply_monitor = reg_wdata_in[rsr_pkg::RSR_BIT_POWER_ON];
    end
    unique case (st_q)
      rsr_pkg::RSR_IDLE:
      begin
        if (|cause)
        begin
          flags_d = cause;
          st_d = rsr_pkg::RSR_HOLD;
          hold_d = rsr_pkg::RSR_HOLD_CYCLES;
        end
      end
      rsr_pkg::RSR_HOLD:
      begin
        hold_d = hold_q - 8'h01;
        if (hold_q == 8'h01)
          st_d = rsr_pkg::RSR_IDLE;
      end
    endcase
  end

  // power-on clears the enables; every other reset leaves them alone
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flags_q <= rsr_pkg::RSR_FLAGS_POR;
      en_q <= rsr_pkg::RSR_ENABLES_POR;
      st_q <= rsr_pkg::RSR_IDLE;
      hold_q <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      flags_q <= flags_d;
      en_q <= en_d;
      st_q <= st_d;
      hold_q <= hold_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign system_reset_out = (st_q == rsr_pkg::RSR_HOLD);
  assign reset_enables_out = en_q;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_sw_force_starts: assert property (
    (wr_hit && reg_wdata_in[rsr_pkg::RSR_BIT_SOFTWARE]) |=> system_reset_out)
  else $error("software force did not start a reset");

  a_sw_flag_reads: assert property (
    (wr_hit && reg_wdata_in[rsr_pkg::RSR_BIT_SOFTWARE] && pin_n_s && !mcd_timeout
     && !wd_s && !mem_s && !sup_low_s && cmp_n_s && !alarm_s)
    |=> flags_q == 8'h10)
  else $error("software reset did not leave only bit 4 set");

  a_one_cause_only: assert property (
    $rose(system_reset_out) |-> $onehot(flags_q))
  else $error("reset recorded other than exactly one cause");

  a_hold_pulse: assert property (
    $rose(system_reset_out) |-> system_reset_out[*8])
  else $error("system reset pulse too short");

  a_ro_bits_kept: assert property (
    (wr_hit && cause == 8'h00) |=> flags_q == $past(flags_q))
  else $error("a write changed the cause flags");

  a_enable_write: assert property (
    wr_hit |=> en_q == {$past(reg_wdata_in[7]), $past(reg_wdata_in[5]),
                        $past(reg_wdata_in[2]), $past(reg_wdata_in[1])})
  else $error("enable bits did not take the written value");

  a_lp_blocks_sources: assert property (
    ($rose(system_reset_out) && $past(lp_s)) |-> !flags_q.watchdog && !flags_q.missing_clock)
  else $error("watchdog or missing clock reset during low power");

  a_supply_needs_both: assert property (
    ($rose(system_reset_out) && flags_q.power_on) |-> $past(en_q.supply_monitor && mon_on_s))
  else $error("supply reset without both enables");

  a_read_answer: assert property (
    (rd_hit && !(|cause)) |=> reg_rdata_out == flags_q)
  else $error("register read returned wrong value");

endmodule
`default_nettype wire

/* File: dv/test_reset_source_register.sv */
// testbench for the reset cause register block
`timescale 1ns/100ps
`default_nettype none
module test_reset_source_register;
  localparam int MCD_CYC = 20;
  localparam logic [7:0] ADDR = rsr_pkg::RSR_CAUSE_ADDR;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_page_in = 4'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic alarm = 1'b0;
  logic mem_err = 1'b0;
  logic cmp_n = 1'b1;
  logic wdog = 1'b0;
  logic sup_low = 1'b0;
  logic sup_en = 1'b1;
  logic pin_n = 1'b1;
  logic low_pwr = 1'b0;
  logic beat = 1'b0;
  logic beat_run = 1'b1;
  logic system_reset_out;
  rsr_pkg::rsr_en_t reset_enables_out;
  int n_errors = 0;
  int num_checks = 0;

  rsr_reset_cause #(.MCD_TIMEOUT_CYCLES(MCD_CYC)) DUT (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .reg_page_in(reg_page_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .clock_alarm_event_in(alarm),
    .memory_error_in(mem_err), .comparator_trip_n_in(cmp_n),
    .watchdog_overflow_in(wdog), .supply_low_in(sup_low),
    .supply_monitor_enable_in(sup_en), .ext_reset_n_in(pin_n),
    .low_power_in(low_pwr), .core_clock_beat_in(beat),
    .system_reset_out(system_reset_out), .reset_enables_out(reset_enables_out));

  // clock and the watched clock beat, which stalls when beat_run drops
  initial
  begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in) if (beat_run) beat <= ~beat;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobes are raised for exactly one edge, inputs move on the falling edge
  task automatic reg_write(input logic [7:0] data);
    @(negedge clk_sys_in);
    reg_addr_in = ADDR;
    reg_wdata_in = data;
    reg_wr_in = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk_sys_in);
    reg_page_in = page;
    reg_addr_in = addr;
    reg_rd_in = 1'b1;
    @(negedge clk_sys_in);
    reg_rd_in = 1'b0;
    check("read data", reg_rdata_out, exp);
    reg_page_in = 4'h0;
  endtask

  task automatic quiet();
    {alarm, mem_err, wdog, sup_low, low_pwr} = 5'h00;
    {cmp_n, pin_n, sup_en, beat_run} = 4'hf;
  endtask

  // wait for a reset pulse, release the source, time the pulse, read the cause
  task automatic expect_reset(input logic [7:0] exp, input int bound);
    int n;
    n = 0;
    while (system_reset_out !== 1'b1 && n < bound)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    check("reset start", {7'h00, system_reset_out}, 8'h01);
    quiet();
    n = 0;
    while (system_reset_out === 1'b1 && n < 40)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    check("pulse length", n[7:0], rsr_pkg::RSR_HOLD_CYCLES);
    reg_read(4'h0, ADDR, exp);
  endtask

  task automatic no_reset(input int cycles);
    logic seen;
    seen = 1'b0;
    repeat (cycles)
    begin
      @(negedge clk_sys_in);
      seen = seen | (system_reset_out !== 1'b0);
    end
    check("no reset", {7'h00, seen}, 8'h00);
  endtask

  task automatic t_power_on();
    reg_read(4'h0, ADDR, rsr_pkg::RSR_FLAGS_POR);
    check("enables", {4'h0, reset_enables_out}, 8'h00);
    reg_read(4'h0, 8'hee, 8'h00);
    reg_read(4'h1, ADDR, 8'h00);
  endtask

  // enable bits only; read-only and force bits must not act
  task automatic t_enables();
    reg_write(8'hef); // monitor already on and settled
    no_reset(20);
    check("enables", {4'h0, reset_enables_out}, 8'h0f);
    reg_read(4'h0, ADDR, 8'h02);
    reg_write(8'hcb);
    check("enables", {4'h0, reset_enables_out}, 8'h09);
    reg_write(8'ha6);
    check("enables", {4'h0, reset_enables_out}, 8'h0f);
  endtask

  task automatic t_software();
    reg_write(8'hb6); // force with the enables rewritten as they stand
    expect_reset(8'h10, 1);
    check("enables kept", {4'h0, reset_enables_out}, 8'h0f);
  endtask

  task automatic t_sources();
    logic [7:0] exp [5] = '{8'h01, 8'h40, 8'h20, 8'h80, 8'h02};
    for (int k = 0; k < 5; k++)
    begin
      @(negedge clk_sys_in);
      case (k)
        0: pin_n = 1'b0;
        1: mem_err = 1'b1;
        2: cmp_n = 1'b0;
        3: alarm = 1'b1;
        default: sup_low = 1'b1;
      endcase
      expect_reset(exp[k], 8);
    end
  endtask

  // sources held off by low power, the monitor's own enable and the enable bits
  task automatic t_masks();
    @(negedge clk_sys_in);
    low_pwr = 1'b1;
    wdog = 1'b1;
    beat_run = 1'b0;
    no_reset(40);
    beat_run = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    low_pwr = 1'b0;
    expect_reset(8'h08, 8);
    sup_en = 1'b0;
    sup_low = 1'b1;
    no_reset(20);
    quiet();
    reg_write(8'h86); // monitor back on before its enable is rewritten
    cmp_n = 1'b0;
    no_reset(20);
    quiet();
  endtask

  task automatic t_missing_clock();
    reg_write(8'ha6);
    beat_run = 1'b0;
    no_reset(15);
    expect_reset(8'h04, 30);
    @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    check("enables por", {4'h0, reset_enables_out}, 8'h00);
    reg_read(4'h0, ADDR, 8'h02);
  endtask

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: the whole run needs well under ten microseconds
  initial
  begin
    #40000;
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (3) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    t_power_on();
    t_enables();
    t_software();
    t_sources();
    t_masks();
    t_missing_clock();
    summarize();
  end
endmodule
`default_nettype wire
